// file: common/ebtp_params.svh
`ifndef EBTP_PARAMS_SVH
`define EBTP_PARAMS_SVH

// Register byte offsets on the APB window
`define EBTP_OFF_CONTROL 8'h00
`define EBTP_OFF_SCALE 8'h04
`define EBTP_OFF_COUNT 8'h08
`define EBTP_OFF_BOUND 8'h0C
`define EBTP_OFF_STATUS 8'h10

// Control register fields
`define EBTP_CTL_SRC_HI 7
`define EBTP_CTL_SRC_LO 4
`define EBTP_CTL_ROUTE_HI 3
`define EBTP_CTL_ROUTE_LO 2
`define EBTP_CTL_PWM_BIT 1

// Scale register fields
`define EBTP_SCL_SHORT_BIT 7
`define EBTP_SCL_PRE_HI 6
`define EBTP_SCL_PRE_LO 5
`define EBTP_SCL_DIV_HI 4
`define EBTP_SCL_DIV_LO 0

// Status register field
`define EBTP_STS_WRAP_BIT 0

// Reset values
`define EBTP_RST_CONTROL 8'h00
`define EBTP_RST_SCALE 8'h00
`define EBTP_RST_COUNT 8'h00
`define EBTP_RST_BOUND 8'h00

// Clock source codes in the control upper nibble
`define EBTP_SRC_SYSTEM 4'h1
`define EBTP_SRC_FAST 4'h2
`define EBTP_SRC_SLOW 4'h3
`define EBTP_SRC_XTAL 4'h4
`define EBTP_SRC_PA0 4'h5
`define EBTP_SRC_PB0 4'h6
`define EBTP_SRC_PA4 4'h7
`define EBTP_SRC_CMP 4'h8

// Prescaler terminal counts for /1, /4, /16, /64
`define EBTP_PRE_LIM1 6'h00
`define EBTP_PRE_LIM4 6'h03
`define EBTP_PRE_LIM16 6'h0F
`define EBTP_PRE_LIM64 6'h3F

// Terminal counts of the PWM resolutions
`define EBTP_MAX_8BIT 8'hFF
`define EBTP_MAX_7BIT 8'h7F
`define EBTP_MAX_6BIT 8'h3F

`endif

// file: common/ebtp_pkg.sv
`include "ebtp_params.svh"

package ebtp_pkg;

    // Operating mode of the timer
    typedef enum logic {
        EBTP_PERIOD,
        EBTP_PWM
    } ebtp_mode_t;

    // Complete register state of the timer
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] scale;
        logic [7:0] count;
        logic [7:0] bound;
        logic wrap_flag;
        logic [5:0] pre_cnt;
        logic [4:0] div_cnt;
        logic wave;
        logic src_prev;
        logic out_lvl;
        logic [2:0] pin;
        logic [2:0] pin_oe;
        logic [31:0] prdata;
    } ebtp_state_t;

endpackage : ebtp_pkg

// file: hw/ebtp_timer.sv
// Notes on behaviour
// RQ1: Control upper nibble picks timer clock source.
// RQ2: Control bits 3:2 route output to pin.
// RQ3: Routed output overrides pin direction entirely.
// RQ4: Prescaler divides source by 1/4/16/64.
// RQ5: Five-bit scaler further divides prescaled clock.
// RQ6: Eight-bit up counter, software readable and writable.
// RQ7: Counter clears after reaching the bound.
// RQ8: Bound sets period or PWM duty.
// RQ9: Period mode and PWM mode supported.
// RQ10: PWM resolution selectable 6, 7, 8 bits.
// RQ11: Period mode output has half duty.
// RQ12: Comparator high stops PWM when option enabled.
// RQ13: Second instance routes to port B 5-7; SECOND_TIMER is unused, both instances drive the same pin_o.
// RQ14: Fast oscillator source keeps running during halt.
// RQ15: Period frequency is source over 2(K+1)S1(S2+1).
// RQ16: Eight-bit PWM period 256, duty (K+1)/256.
// RQ17: Short PWM period 64 or 128 by option.
// RQ18: Bound at resolution maximum keeps output high.
// RQ19: PWM high while count at or below bound.
// RQ20: Period wrap toggles output, sets event flag.
`include "ebtp_params.svh"

module ebtp_timer
    import ebtp_pkg::*;
#(
    parameter int SHORT_PWM_BITS = 7,  // 6 or 7, build choice for the short PWM
    parameter bit CMP_GATE = 1'b0,     // Comparator gating option
    parameter bit SECOND_TIMER = 1'b0  // Unused by the logic; pin_o is the same in either instance
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic fast_osc_i,
    input wire logic slow_osc_i,
    input wire logic xtal_osc_i,
    input wire logic port_a_bit0_i,
    input wire logic port_b_bit0_i,
    input wire logic port_a_bit4_i,
    input wire logic comparator_i,
    input wire logic emulator_halt_i,
    output logic [2:0] pin_o,
    output logic [2:0] pin_oe_o,
    output logic timer_counting_clock_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Prescaler terminal count for the selected ratio
    function automatic logic [5:0] pre_limit(input logic [1:0] sel);
        case (sel)
            2'h0: pre_limit = `EBTP_PRE_LIM1;
            2'h1: pre_limit = `EBTP_PRE_LIM4;
            2'h2: pre_limit = `EBTP_PRE_LIM16;
            default: pre_limit = `EBTP_PRE_LIM64;
        endcase
    endfunction

    // One-hot pin enables from the route field, zero means unrouted
    function automatic logic [2:0] route_dec(input logic [1:0] route);
        case (route)
            2'h1: route_dec = 3'h1;
            2'h2: route_dec = 3'h2;
            2'h3: route_dec = 3'h4;
            default: route_dec = 3'h0;
        endcase
    endfunction

    // Short PWM terminal count is fixed at build time
    localparam logic [7:0] SHORT_MAX = (SHORT_PWM_BITS == 6) ? `EBTP_MAX_6BIT : `EBTP_MAX_7BIT;

    ////////////////////////////////////////////////////////////////////////////////
    // State and decode

    ebtp_state_t s_q;  // Registered state
    ebtp_state_t s_d;  // Next state
    logic setup;       // APB setup cycle
    logic access;      // APB access cycle
    logic wr;          // Write taking effect this edge
    logic hit;         // Address maps to a register
    logic src_lvl;     // Level of the chosen source
    logic src_tick;    // Counting step from the source
    logic run;         // Source step after halt gating
    logic pre_tick;    // Prescaler output step
    logic tmr_tick;    // Timer counting clock step
    logic wrap;        // Period counter clears at the bound
    logic pwm_mode_d;  // Next mode is PWM
    logic [7:0] res_max_d;  // Next PWM terminal count
    logic gate;        // Comparator holds PWM off
    ebtp_mode_t mode;  // Current mode

    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign wr = access && pwrite_i && hit;
    assign hit = (paddr_i == `EBTP_OFF_CONTROL) || (paddr_i == `EBTP_OFF_SCALE) ||
                 (paddr_i == `EBTP_OFF_COUNT) || (paddr_i == `EBTP_OFF_BOUND) ||
                 (paddr_i == `EBTP_OFF_STATUS);
    assign mode = s_q.control[`EBTP_CTL_PWM_BIT] ? EBTP_PWM : EBTP_PERIOD;

    // Zero wait states; errors only on unmapped words
    assign pready_o = 1'b1;
    assign pslverr_o = access && !hit;
    assign prdata_o = s_q.prdata;
    assign pin_o = s_q.pin;
    assign pin_oe_o = s_q.pin_oe;
    assign timer_counting_clock_o = s_q.out_lvl;

    ////////////////////////////////////////////////////////////////////////////////
    // Source selection and clock chain

    // Pick the source level; unknown codes stop the timer
    always_comb begin
        // RQ1 source select
        case (s_q.control[`EBTP_CTL_SRC_HI:`EBTP_CTL_SRC_LO])
            `EBTP_SRC_FAST: src_lvl = fast_osc_i;
            `EBTP_SRC_SLOW: src_lvl = slow_osc_i;
            `EBTP_SRC_XTAL: src_lvl = xtal_osc_i;
            `EBTP_SRC_PA0: src_lvl = port_a_bit0_i;
            `EBTP_SRC_PB0: src_lvl = port_b_bit0_i;
            `EBTP_SRC_PA4: src_lvl = port_a_bit4_i;
            `EBTP_SRC_CMP: src_lvl = comparator_i;
            default: src_lvl = 1'b0;
        endcase
    end

    // Slow sources count on rising edges; system clock steps every cycle
    // Switching from a low source to a high one can show one extra edge; stop first
    assign src_tick = (s_q.control[`EBTP_CTL_SRC_HI:`EBTP_CTL_SRC_LO] == `EBTP_SRC_SYSTEM) ||
                      (src_lvl && !s_q.src_prev);
    // RQ14 halt bypass
    assign run = src_tick && (!emulator_halt_i ||
                 s_q.control[`EBTP_CTL_SRC_HI:`EBTP_CTL_SRC_LO] == `EBTP_SRC_FAST);
    assign gate = CMP_GATE && comparator_i;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    // Counter, waveform, bus writes and read data in one place
    always_comb begin
        s_d = s_q;
        pre_tick = 1'b0;
        tmr_tick = 1'b0;
        wrap = 1'b0;
        s_d.src_prev = src_lvl;
        // RQ4 prescaler
        if (run) begin
            if (s_q.pre_cnt >= pre_limit(s_q.scale[`EBTP_SCL_PRE_HI:`EBTP_SCL_PRE_LO])) begin
                s_d.pre_cnt = 6'h00;
                pre_tick = 1'b1;
            end else begin
                s_d.pre_cnt = s_q.pre_cnt + 6'h01;
            end
        end
        // RQ5 RQ15 scaler stage
        if (pre_tick) begin
            if (s_q.div_cnt >= s_q.scale[`EBTP_SCL_DIV_HI:`EBTP_SCL_DIV_LO]) begin
                s_d.div_cnt = 5'h00;
                tmr_tick = 1'b1;
            end else begin
                s_d.div_cnt = s_q.div_cnt + 5'h01;
            end
        end
        // RQ6 up counting
        if (tmr_tick) begin
            if (mode == EBTP_PWM) begin
                // RQ16 RQ17 PWM frame length
                if (s_q.count >= (s_q.scale[`EBTP_SCL_SHORT_BIT] ? SHORT_MAX
                                                                 : `EBTP_MAX_8BIT)) begin
                    s_d.count = 8'h00;
                end else begin
                    s_d.count = s_q.count + 8'h01;
                end
            // RQ7 clear at bound
            end else if (s_q.count == s_q.bound) begin
                s_d.count = 8'h00;
                wrap = 1'b1;
            end else begin
                s_d.count = s_q.count + 8'h01;
            end
        end
        // RQ20 RQ11 toggle per wrap
        if (wrap) begin
            s_d.wave = !s_q.wave;
        end
        // Software writes override counting in the same cycle
        if (wr) begin
            case (paddr_i)
                `EBTP_OFF_CONTROL: s_d.control = pwdata_i[7:0];
                `EBTP_OFF_SCALE: begin
                    // Restart both dividers so a smaller ratio never starts out of range
                    s_d.scale = pwdata_i[7:0];
                    s_d.pre_cnt = 6'h00;
                    s_d.div_cnt = 5'h00;
                end
                // RQ6 software load
                `EBTP_OFF_COUNT: s_d.count = pwdata_i[7:0];
                `EBTP_OFF_BOUND: s_d.bound = pwdata_i[7:0];
                default: s_d.count = s_d.count;
            endcase
        end
        // RQ20 event flag, set beats clear
        s_d.wrap_flag = (s_q.wrap_flag && !(wr && paddr_i == `EBTP_OFF_STATUS &&
                         pwdata_i[`EBTP_STS_WRAP_BIT])) || wrap;
        // RQ9 mode chooses waveform
        pwm_mode_d = s_d.control[`EBTP_CTL_PWM_BIT];
        // RQ10 resolution
        res_max_d = s_d.scale[`EBTP_SCL_SHORT_BIT] ? SHORT_MAX : `EBTP_MAX_8BIT;
        if (pwm_mode_d) begin
            // RQ19 RQ18 RQ8 duty compare, RQ12 gating
            s_d.out_lvl = ((s_d.count <= s_d.bound) || (s_d.bound >= res_max_d)) && !gate;
        end else begin
            s_d.out_lvl = s_d.wave;
        end
        // RQ2 RQ13 RQ3 pin route with forced enable
        s_d.pin_oe = route_dec(s_d.control[`EBTP_CTL_ROUTE_HI:`EBTP_CTL_ROUTE_LO]);
        s_d.pin = s_d.pin_oe & {3{s_d.out_lvl}};
        // Read data captured in the setup cycle
        if (setup) begin
            case (paddr_i)
                `EBTP_OFF_CONTROL: s_d.prdata = {24'h000000, s_q.control};
                `EBTP_OFF_SCALE: s_d.prdata = {24'h000000, s_q.scale};
                `EBTP_OFF_COUNT: s_d.prdata = {24'h000000, s_q.count};
                `EBTP_OFF_BOUND: s_d.prdata = {24'h000000, s_q.bound};
                `EBTP_OFF_STATUS: s_d.prdata = {31'h00000000, s_q.wrap_flag};
                default: s_d.prdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    // Single register bank; reset loads constants only
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.control <= `EBTP_RST_CONTROL;
            s_q.scale <= `EBTP_RST_SCALE;
            s_q.count <= `EBTP_RST_COUNT;
            s_q.bound <= `EBTP_RST_BOUND;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    // Bound wrap in period mode
    bound_clear_a: assert property (tmr_tick && mode == EBTP_PERIOD && !wr &&  // RQ7
        s_q.count == s_q.bound |=> s_q.count == 8'h00)
        else $error("counter did not clear at bound");

    // Plain increment in period mode whenever the count is off the bound
    count_up_a: assert property (tmr_tick && !wr && mode == EBTP_PERIOD &&  // RQ6
        s_q.count != s_q.bound |=> s_q.count == $past(s_q.count) + 8'h01)
        else $error("counter did not step up");

    // Counter holds without a step
    count_hold_a: assert property (!tmr_tick && !wr |=>  // RQ6
        s_q.count == $past(s_q.count))
        else $error("counter moved without a step");

    // Period wrap toggles wave and raises the flag
    wrap_toggle_a: assert property (wrap |=> s_q.wave != $past(s_q.wave) &&  // RQ20
        s_q.wrap_flag)
        else $error("wrap did not toggle or flag");

    // Halted core freezes non-fast sources
    halt_freeze_a: assert property (emulator_halt_i &&  // RQ14
        s_q.control[7:4] != `EBTP_SRC_FAST |-> !run)
        else $error("timer ran during halt");

    // Fast source is not stopped by halt
    halt_bypass_a: assert property (s_q.control[7:4] == `EBTP_SRC_FAST &&  // RQ14
        fast_osc_i && !s_q.src_prev |-> run)
        else $error("fast source stopped by halt");

    // Comparator gating forces PWM low
    cmp_gate_a: assert property (CMP_GATE && pwm_mode_d && comparator_i |=>  // RQ12
        !s_q.out_lvl)
        else $error("PWM not gated by comparator");

    // Full bound keeps PWM high
    pwm_full_a: assert property (pwm_mode_d && s_d.bound == `EBTP_MAX_8BIT && !gate |=>  // RQ18
        s_q.out_lvl)
        else $error("PWM not high at full bound");

    // Routed pin carries the waveform
    pin_route_a: assert property (pin_oe_o != 3'h0 |-> (pin_o == pin_oe_o) ==  // RQ3
        s_q.out_lvl)
        else $error("routed pin does not follow output");

    // Prescaler never exceeds the selected ratio
    pre_range_a: assert property (s_q.pre_cnt <= pre_limit(s_q.scale[6:5]))  // RQ4
        else $error("prescaler out of range");

    // Writing one to the status bit clears the flag when no wrap competes
    flag_clear_a: assert property (wr && paddr_i == `EBTP_OFF_STATUS &&  // RQ20
        pwdata_i[`EBTP_STS_WRAP_BIT] && !wrap |=> !s_q.wrap_flag)
        else $error("wrap flag not cleared");

    // At most one pin is overridden at a time
    pin_onehot_a: assert property ($onehot0(pin_oe_o))  // RQ2
        else $error("more than one pin routed");

    // A scale write restarts both dividers
    scale_clear_a: assert property (wr && paddr_i == `EBTP_OFF_SCALE |=>  // RQ4
        s_q.pre_cnt == 6'h00 && s_q.div_cnt == 5'h00)
        else $error("dividers not restarted");

    // Eight-bit PWM frame ends after the full count
    pwm_wrap_a: assert property (tmr_tick && mode == EBTP_PWM && !wr &&  // RQ16
        !s_q.scale[`EBTP_SCL_SHORT_BIT] && s_q.count == `EBTP_MAX_8BIT |=>
        s_q.count == 8'h00)
        else $error("PWM frame did not wrap at full count");

    // Period mode drives the toggled wave out unchanged
    period_wave_a: assert property (!pwm_mode_d |=> s_q.out_lvl == s_q.wave)  // RQ11
        else $error("period output differs from wave");

    // Count read returns the value seen at the setup edge
    read_back_a: assert property (setup && paddr_i == `EBTP_OFF_COUNT |=>  // RQ6
        prdata_o == {24'h000000, $past(s_q.count)})
        else $error("count read back wrong");

    // Main scenarios
    wrap_seen_c: cover property (wrap);
    pwm_frame_c: cover property (tmr_tick && mode == EBTP_PWM && s_q.count == 8'h00);
    gate_seen_c: cover property (gate && pwm_mode_d);
    count_load_c: cover property (wr && paddr_i == `EBTP_OFF_COUNT);
    halt_run_c: cover property (emulator_halt_i && run);

endmodule // ebtp_timer

// file: test/ebtp_pin_model.sv
////////////////////////////////////////////////////////////////
// Board side of the three timer pins
module ebtp_pin_model (
    input wire logic [2:0] pin_i,  // Timer pin level
    input wire logic [2:0] oe_i,   // Timer override enable
    input wire logic [2:0] ext_i,  // Board drive on each pin
    output logic [2:0] pad_o       // Resolved pad level
);
    timeunit 1ns;
    timeprecision 1ns;
    // timer overrides pin
    // Timer wins whatever direction the pin has
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pad_o[i] = oe_i[i] ? pin_i[i] : ext_i[i];
        end
    end
endmodule // ebtp_pin_model

// file: test/eight_bit_timer_pwm_test.sv
`include "ebtp_params.svh"
module eight_bit_timer_pwm_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SPB = 7;        // Short PWM resolution
    localparam int SP = 1 << SPB;  // Short PWM period
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdv;               // Last read data
    logic pready;
    logic pslverr;
    logic last_err;                 // Last slave error
    logic [6:0] src = 7'h00;        // Fast, slow, xtal, pa0, pb0, pa4, cmp
    logic halt = 1'b0;
    logic [2:0] pin;
    logic [2:0] pin_oe;
    logic [2:0] pad;
    logic [2:0] ext = 3'h7;         // Board pulls against the timer
    logic wave;
    int miscompares = 0;
    int compares = 0;
    ////////////////////////////////////////////////////////////////
    // 125 MHz clock
    always #4 mclk = ~mclk;
    ebtp_timer #(.SHORT_PWM_BITS(SPB), .CMP_GATE(1'b1)) uut (
        .mclk_i(mclk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .fast_osc_i(src[0]),
        .slow_osc_i(src[1]), .xtal_osc_i(src[2]), .port_a_bit0_i(src[3]),
        .port_b_bit0_i(src[4]), .port_a_bit4_i(src[5]), .comparator_i(src[6]),
        .emulator_halt_i(halt), .pin_o(pin), .pin_oe_o(pin_oe),
        .timer_counting_clock_o(wave));
    ebtp_pin_model pins (.pin_i(pin), .oe_i(pin_oe), .ext_i(ext), .pad_o(pad));
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // One APB transfer; waits for pready, only the watchdog ends a stall
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input string m);
        apb(1'b0, a, 32'h0);
        chk(rdv, {24'h0, e}, m);
    endtask
    // Rising edges on one source input
    task pulse(input int i, input int n);
        repeat (n) begin
            @(posedge mclk);
            src[i] <= 1'b1;
            @(posedge mclk);
            src[i] <= 1'b0;
        end
        @(posedge mclk);
    endtask
    // Skip two toggles, then time one half period
    task half(input int e, input string m);
        int n;
        logic r;
        for (int k = 0; k < 3; k++) begin
            r = wave;
            n = 0;
            while (wave === r && n < 5000) begin
                @(negedge mclk);
                n++;
            end
        end
        chk(n, e, m);
    endtask
    // High cycles over a span, after a settling span
    task high(input int s, input int e, input string m);
        int n;
        n = 0;
        repeat (s) @(negedge mclk);
        repeat (s) begin
            @(negedge mclk);
            if (wave === 1'b1) n++;
        end
        chk(n, e, m);
    endtask
    task print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        $display("Error %0t: watchdog", $time);
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd(`EBTP_OFF_CONTROL, 8'h00, "ctl reset");
        rd(`EBTP_OFF_SCALE, 8'h00, "scl reset");
        rd(`EBTP_OFF_COUNT, 8'h00, "cnt reset");
        rd(8'h14, 8'h00, "unmapped");
        chk(last_err, 1'b1, "slverr");
        wr(`EBTP_OFF_COUNT, 8'h5A);
        rd(`EBTP_OFF_COUNT, 8'h5A, "cnt rw");
        wr(`EBTP_OFF_BOUND, 8'hFF);
        // Every external source, three edges each
        for (int c = 2; c <= 8; c++) begin
            wr(`EBTP_OFF_CONTROL, 8'(c << 4));
            wr(`EBTP_OFF_COUNT, 8'h00);
            pulse(c - 2, 3);
            rd(`EBTP_OFF_COUNT, 8'h03, "src count");
        end
        // Halt freezes the slow oscillator but not the fast one
        halt <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(`EBTP_OFF_CONTROL, k ? 8'h30 : 8'h20);
            wr(`EBTP_OFF_COUNT, 8'h00);
            pulse(k, 3);
            rd(`EBTP_OFF_COUNT, k ? 8'h00 : 8'h03, "halt");
        end
        halt <= 1'b0;
        wr(`EBTP_OFF_BOUND, 8'h01);
        for (int r = 0; r < 4; r++) begin
            wr(`EBTP_OFF_CONTROL, 8'(8'h10 | (r << 2)));
            @(negedge mclk);
            chk(pin_oe, r ? 3'(1 << (r - 1)) : 3'h0, "route");
            chk(pad & pin_oe, {3{wave}} & pin_oe, "pad");
        end
        wr(`EBTP_OFF_CONTROL, 8'h14);
        wr(`EBTP_OFF_BOUND, 8'h03);
        half(4, "period");
        // All prescalers with scaler two
        for (int p = 0; p < 4; p++) begin
            wr(`EBTP_OFF_SCALE, 8'((p << 5) | 1));
            wr(`EBTP_OFF_BOUND, 8'h01);
            wr(`EBTP_OFF_COUNT, 8'h00);
            half(2 * (4 ** p) * 2, "prescale");
        end
        wr(`EBTP_OFF_SCALE, 8'h1F);
        wr(`EBTP_OFF_BOUND, 8'h00);
        half(32, "scaler max");
        rd(`EBTP_OFF_STATUS, 8'h01, "wrap flag");
        wr(`EBTP_OFF_CONTROL, 8'h00);
        wr(`EBTP_OFF_STATUS, 8'h01);
        rd(`EBTP_OFF_STATUS, 8'h00, "flag clear");
        wr(`EBTP_OFF_SCALE, 8'h00);
        wr(`EBTP_OFF_BOUND, 8'h09);
        wr(`EBTP_OFF_CONTROL, 8'h1A);
        high(512, 20, "pwm8");
        wr(`EBTP_OFF_BOUND, 8'hFF);
        high(256, 256, "pwm8 full");
        wr(`EBTP_OFF_SCALE, 8'h80);
        wr(`EBTP_OFF_BOUND, 8'h1F);
        high(2 * SP, 64, "short pwm");
        wr(`EBTP_OFF_BOUND, 8'(SP - 1));
        high(2 * SP, 2 * SP, "short full");
        wr(`EBTP_OFF_BOUND, 8'h1F);
        // Comparator gating stops then resumes
        @(posedge mclk);
        src[6] <= 1'b1;
        high(2 * SP, 0, "gated");
        @(posedge mclk);
        src[6] <= 1'b0;
        high(2 * SP, 64, "resumed");
        print_verdict();
    end
endmodule // eight_bit_timer_pwm_test
